/* design/fill_ecc_error_handler.sv */
// fill ecc error handler: classify, log, post exceptions, run recovery
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "fill_ecc_error_handler_cfg.svh"

// What this block does
// - icache memory single-bit: immediate check plus interrupt
// - unused bad fill: cache unchanged, log, interrupt
// - used bad fill: write bad dest, keep queue
// - replay trap, stall map stage until corrected
// - error read type: evict to victim, write back
// - used memory fill: set flag, log address
// - correctable fill or probe: capture both syndromes
// - after scrub retry load, set load flag
// - speculative load: interrupt only, status stays zero
// - probe single-bit: interrupt, latch, forward uncorrected
// - probe: flag, address, syndromes, no correction
// - double-bit fill: detect, four status codes
// - machine check deferred in privileged firmware mode
// - double-bit memory fill keeps original check bits
// - icache parity: flush, parity flag, interrupt
// - tag parity at issue: data fault, log va
// - tag parity at retry: machine check, port flag
// - data cache load error: update address bits 19:6 only
// - victim read error: scrub silently
// - small store error: scrub, store flag, interrupt
// - second store error: no correction, machine check
// - non-target quadword error left for firmware
module fill_ecc_error_handler
  import fill_ecc_error_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // error event from the ecc and parity checkers
  input  wire err_event_t err_in,
  input  wire logic       read_err_type,
  // processor mode
  input  wire logic       privileged_firmware_mode,
  // register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [63:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [63:0]     reg_rdata,
  // exceptions
  output logic            machine_check,
  output logic            corrected_read_interrupt,
  // recovery commands
  output recovery_t       recovery
);

  // scrub sequence states
  typedef enum logic [2:0] {
    st_idle   = 3'b000,
    st_wait   = 3'b001,
    st_evict  = 3'b010,
    st_write  = 3'b011,
    st_retry  = 3'b100
  } scrub_state_t;

  // software view
  logic [3:0]  cache_status_reg, cache_status_next;   // fill status code
  logic [42:6] error_address_reg, error_address_next;  // block address
  logic [7:0]  syn0_reg, syn0_next;                    // quadword 0 syndrome
  logic [7:0]  syn1_reg, syn1_next;                    // quadword 1 syndrome
  logic [4:0]  data_cache_status_reg, data_cache_status_next;
  logic        parity_flag_reg, parity_flag_next;      // instruction status
  logic        tag_parity_flag_reg, tag_parity_flag_next;
  logic [63:0] fault_va_reg, fault_va_next;
  logic [1:0]  control_reg, control_next;              // check and interrupt enables
  logic        machine_check_pend_reg, machine_check_pend_next;          // posted machine check
  logic        crd_pend_reg, crd_pend_next;            // posted interrupt
  logic [63:0] rdata_reg, rdata_next;
  // scrub engine
  scrub_state_t scrub_reg, scrub_next;
  logic [2:0]  scrub_cnt_reg, scrub_cnt_next;
  // registered recovery outputs: one-cycle pulses, a two-cycle evict_to_victim, plus retain_lq and map_stall levels
  recovery_t   rec_reg, rec_next;

  // decoded classes of the incoming event
  logic ev_fill_sgl;
  logic ev_fill_dbl;
  logic ev_machine_check;
  logic ev_crd;

  // any fill error, single- or double-bit
  function automatic logic is_fill(input err_event_t e);
    is_fill = e.valid && (e.src == src_instr_fill || e.src == src_data_fill);
  endfunction : is_fill

  // write hits a given register
  function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] off, input logic w);
    wr_hit = w && (a == off);
  endfunction : wr_hit

  // classify the event combinationally
  always_comb begin
    ev_fill_sgl = is_fill(err_in) && !err_in.double_bit;
    ev_fill_dbl = is_fill(err_in) && err_in.double_bit;
    ev_machine_check     = 1'b0;
    ev_crd      = 1'b0;
    if (err_in.valid) begin
      unique case (err_in.src)
        src_instr_fill: begin
          ev_machine_check = 1'b1;
          ev_crd  = !err_in.double_bit;
        end
        src_data_fill: begin
          ev_machine_check = err_in.double_bit;
          ev_crd  = !err_in.double_bit;
        end
        src_probe:     ev_crd  = 1'b1;
        src_dc_load:   ev_crd  = 1'b1;
        src_dc_store: begin
          ev_machine_check = err_in.second_store;
          ev_crd  = !err_in.second_store;
        end
        src_ic_parity: ev_crd  = 1'b1;
        src_tag_retry: ev_machine_check = 1'b1;
        default: begin
          ev_machine_check = 1'b0;                                    // victim and issue tag: none
          ev_crd  = 1'b0;
        end
      endcase
    end
  end

  // log registers: a logged value holds until software clears it or a later event overwrites it
  always_comb begin
    cache_status_next      = cache_status_reg;
    error_address_next     = error_address_reg;
    syn0_next              = syn0_reg;
    syn1_next              = syn1_reg;
    data_cache_status_next = data_cache_status_reg;
    parity_flag_next       = parity_flag_reg;
    tag_parity_flag_next   = tag_parity_flag_reg;
    fault_va_next          = fault_va_reg;
    control_next           = control_reg;
    // software clears first, so a same-cycle event below wins
    if (wr_hit(reg_addr, `ADDR_CACHE_STATUS, reg_wr))
      cache_status_next = `CSTAT_NONE;
    if (wr_hit(reg_addr, `ADDR_DATA_CACHE_STAT, reg_wr))
      data_cache_status_next = data_cache_status_reg & ~reg_wdata[4:0];
    if (wr_hit(reg_addr, `ADDR_INSTR_STATUS, reg_wr) && reg_wdata[0])
      parity_flag_next = 1'b0;
    if (wr_hit(reg_addr, `ADDR_MM_STATUS, reg_wr) && reg_wdata[0])
      tag_parity_flag_next = 1'b0;
    if (wr_hit(reg_addr, `ADDR_CONTROL, reg_wr))
      control_next = reg_wdata[1:0];
    if (err_in.valid) begin
      // fills: speculative loads leave status and address untouched
      if (is_fill(err_in) && !err_in.speculative) begin
        // a later error may overwrite the address under heavy traffic
        error_address_next = err_in.block_addr;
        if (err_in.double_bit)
          cache_status_next = err_in.src == src_instr_fill
            ? (err_in.from_board ? `CSTAT_INSTR_BRD_DBL : `CSTAT_INSTR_MEM_DBL)
            : (err_in.from_board ? `CSTAT_DATA_BRD_DBL : `CSTAT_DATA_MEM_DBL);
        else if (err_in.src == src_instr_fill)
          cache_status_next = err_in.from_board ? `CSTAT_INSTR_BRD_SGL
                                                : `CSTAT_INSTR_MEM_SGL;
        else
          cache_status_next = err_in.from_board ? `CSTAT_DATA_BRD_SGL
                                                : `CSTAT_DATA_MEM_SGL;
        if (!err_in.double_bit) begin
          syn0_next = err_in.syn0;
          syn1_next = err_in.syn1;
        end
      end
      if (err_in.src == src_probe) begin
        cache_status_next  = `CSTAT_PROBE_BRD_SGL;
        error_address_next = err_in.block_addr;
        syn0_next          = err_in.syn0;
        syn1_next          = err_in.syn1;
      end
      if (err_in.src == src_dc_load) begin
        data_cache_status_next[`DCS_LOAD_ECC] = 1'b1;
        if (!err_in.speculative) begin
          cache_status_next = `CSTAT_DATA_DC_SGL;
          error_address_next[19:6] = err_in.block_addr[19:6];
        end
      end
      if (err_in.src == src_dc_store) begin
        data_cache_status_next[`DCS_STORE_ECC] = 1'b1;
        if (err_in.second_store)
          data_cache_status_next[`DCS_SECOND_ERR] = 1'b1;
      end
      if (err_in.src == src_ic_parity)
        parity_flag_next = 1'b1;
      if (err_in.src == src_tag_issue) begin
        tag_parity_flag_next = 1'b1;
        fault_va_next        = err_in.vaddr;
      end
      if (err_in.src == src_tag_retry) begin
        if (err_in.port_one)
          data_cache_status_next[`DCS_TAG_PARITY_PORT_ONE] = 1'b1;
        else
          data_cache_status_next[`DCS_TAG_PARITY_PORT_ZERO] = 1'b1;
      end
    end
    // load flag set once the scrubbed load is retried
    if (scrub_reg == st_retry)
      data_cache_status_next[`DCS_LOAD_ECC] = 1'b1;
  end

  // pending exceptions; set wins over a software clear
  always_comb begin
    machine_check_pend_next = machine_check_pend_reg;
    crd_pend_next  = crd_pend_reg;
    if (wr_hit(reg_addr, `ADDR_EXCEPTION, reg_wr)) begin
      if (reg_wdata[`EXC_MACHINE_CHECK_PEND]) machine_check_pend_next = 1'b0;
      if (reg_wdata[`EXC_CRD_PEND])  crd_pend_next  = 1'b0;
    end
    if (ev_machine_check && control_reg[`CTL_MACHINE_CHECK_EN])
      machine_check_pend_next = 1'b1;
    if (ev_crd && control_reg[`CTL_CRD_EN] && !(ev_fill_sgl && err_in.used_by_load
        && !err_in.speculative && err_in.src == src_data_fill))
      crd_pend_next = 1'b1;
    if (scrub_reg == st_retry && control_reg[`CTL_CRD_EN])
      crd_pend_next = 1'b1;
  end

  // scrub engine for a fill quadword that satisfied a load
  always_comb begin
    scrub_next      = scrub_reg;
    scrub_cnt_next  = scrub_cnt_reg;
    unique case (scrub_reg)
      st_idle: begin
        // non-target quadword errors are left for the firmware scrub
        if (ev_fill_sgl && err_in.src == src_data_fill && err_in.used_by_load
            && !err_in.speculative && err_in.target_qw) begin
          scrub_next      = st_wait;
        end
      end
      st_wait: begin
        if (read_err_type) begin
          scrub_next     = st_evict;
          scrub_cnt_next = `SCRUB_EVICT_CYCLES;
        end
      end
      st_evict: begin
        scrub_cnt_next = scrub_cnt_reg - 3'h1;
        if (scrub_cnt_reg == 3'h1)
          scrub_next = st_write;
      end
      st_write: scrub_next = st_retry;
      st_retry: scrub_next = st_idle;
      default:  scrub_next = st_idle;
    endcase
  end

  // recovery command pulses and levels
  always_comb begin
    rec_next = '0;
    if (err_in.valid) begin
      if (err_in.src == src_ic_parity || ev_fill_sgl && err_in.src == src_instr_fill)
        rec_next.icache_flush = 1'b1;
      if (err_in.src == src_tag_issue)
        rec_next.data_fault = 1'b1;
      if (err_in.src == src_probe)
        rec_next.forward_uncorrected = 1'b1;
      if (ev_fill_dbl || is_fill(err_in) && (!err_in.used_by_load
          || !err_in.target_qw))
        rec_next.keep_check_bits = 1'b1;
      if ((err_in.src == src_dc_load && !err_in.speculative)
          || err_in.src == src_dc_victim
          || (err_in.src == src_dc_store && !err_in.second_store))
        rec_next.correct_data = 1'b1;
      if (scrub_reg == st_idle && scrub_next == st_wait) begin
        rec_next.write_bad_dest = 1'b1;
        rec_next.replay_trap    = 1'b1;
      end
    end
    rec_next.retain_lq       = scrub_next != st_idle;
    rec_next.map_stall       = scrub_next != st_idle;
    rec_next.evict_to_victim = scrub_next == st_evict;
    rec_next.write_back_dc   = scrub_next == st_write;
    rec_next.retry_load      = scrub_next == st_retry;
  end

  // read data mux, answered one cycle after the strobe
  always_comb begin
    rdata_next = 64'h0;
    if (reg_rd) begin
      unique case (reg_addr)
        `ADDR_CACHE_STATUS:    rdata_next = {60'h0, cache_status_reg};
        `ADDR_ERROR_ADDRESS:   rdata_next = {21'h0, error_address_reg, 6'h0};
        `ADDR_SYNDROME:        rdata_next = {48'h0, syn1_reg, syn0_reg};
        `ADDR_DATA_CACHE_STAT: rdata_next = {59'h0, data_cache_status_reg};
        `ADDR_INSTR_STATUS:    rdata_next = {63'h0, parity_flag_reg};
        `ADDR_MM_STATUS:       rdata_next = {63'h0, tag_parity_flag_reg};
        `ADDR_FAULT_VA:        rdata_next = fault_va_reg;
        `ADDR_CONTROL:         rdata_next = {62'h0, control_reg};
        `ADDR_EXCEPTION:       rdata_next = {62'h0, crd_pend_reg, machine_check_pend_reg};
        default:               rdata_next = 64'h0;             // unmapped reads zero
      endcase
    end
  end

  // register all state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cache_status_reg      <= `CSTAT_NONE;
      error_address_reg     <= '0;
      syn0_reg              <= 8'h0;
      syn1_reg              <= 8'h0;
      data_cache_status_reg <= 5'h0;
      parity_flag_reg       <= 1'b0;
      tag_parity_flag_reg   <= 1'b0;
      fault_va_reg          <= 64'h0;
      control_reg           <= `RST_CONTROL;
      machine_check_pend_reg         <= 1'b0;
      crd_pend_reg          <= 1'b0;
      rdata_reg             <= 64'h0;
      scrub_reg             <= st_idle;
      scrub_cnt_reg         <= 3'h0;
      rec_reg               <= '0;
    end else begin
      cache_status_reg      <= cache_status_next;
      error_address_reg     <= error_address_next;
      syn0_reg              <= syn0_next;
      syn1_reg              <= syn1_next;
      data_cache_status_reg <= data_cache_status_next;
      parity_flag_reg       <= parity_flag_next;
      tag_parity_flag_reg   <= tag_parity_flag_next;
      fault_va_reg          <= fault_va_next;
      control_reg           <= control_next;
      machine_check_pend_reg         <= machine_check_pend_next;
      crd_pend_reg          <= crd_pend_next;
      rdata_reg             <= rdata_next;
      scrub_reg             <= scrub_next;
      scrub_cnt_reg         <= scrub_cnt_next;
      rec_reg               <= rec_next;
    end
  end

  // check is taken only outside privileged firmware mode; it stays pending there
  assign machine_check            = machine_check_pend_reg && !privileged_firmware_mode;
  assign corrected_read_interrupt = crd_pend_reg;
  assign reg_rdata                = rdata_reg;
  assign recovery                 = rec_reg;

endmodule : fill_ecc_error_handler
`default_nettype wire

/* design/fill_ecc_error_handler_cfg.svh */
// constants for the fill ecc error handler: offsets, field positions, reset values
`ifndef FILL_ECC_ERROR_HANDLER_CFG_SVH
`define FILL_ECC_ERROR_HANDLER_CFG_SVH
// register offsets (word addresses on the plain port)
`define ADDR_CACHE_STATUS     4'h0
`define ADDR_ERROR_ADDRESS    4'h1
`define ADDR_SYNDROME         4'h2
`define ADDR_DATA_CACHE_STAT  4'h3
`define ADDR_INSTR_STATUS     4'h4
`define ADDR_MM_STATUS        4'h5
`define ADDR_FAULT_VA         4'h6
`define ADDR_CONTROL          4'h7
`define ADDR_EXCEPTION        4'h8
// cache status codes
`define CSTAT_NONE            4'h0
`define CSTAT_INSTR_MEM_SGL   4'h1
`define CSTAT_DATA_MEM_SGL    4'h2
`define CSTAT_PROBE_BRD_SGL   4'h3
`define CSTAT_INSTR_BRD_DBL   4'h4
`define CSTAT_DATA_BRD_DBL    4'h5
`define CSTAT_INSTR_MEM_DBL   4'h6
`define CSTAT_DATA_MEM_DBL    4'h7
`define CSTAT_DATA_DC_SGL     4'h8
`define CSTAT_INSTR_BRD_SGL   4'h9
`define CSTAT_DATA_BRD_SGL    4'ha
// data cache status bit positions
`define DCS_TAG_PARITY_PORT_ZERO          0
`define DCS_TAG_PARITY_PORT_ONE          1
`define DCS_LOAD_ECC          2
`define DCS_STORE_ECC         3
`define DCS_SECOND_ERR        4
// control bit positions
`define CTL_MACHINE_CHECK_EN           0
`define CTL_CRD_EN            1
// exception register bit positions
`define EXC_MACHINE_CHECK_PEND         0
`define EXC_CRD_PEND          1
// reset values
`define RST_CONTROL           2'h3
// scrub sequence lengths in cycles
`define SCRUB_EVICT_CYCLES    3'h2
`endif

/* design/fill_ecc_error_pkg.sv */
// types shared by the fill ecc error handler
package fill_ecc_error_pkg;
  // source of an error event
  typedef enum logic [3:0] {
    src_none         = 4'h0,
    src_instr_fill   = 4'h1,
    src_data_fill    = 4'h2,
    src_probe        = 4'h3,
    src_dc_load      = 4'h4,
    src_dc_store     = 4'h5,
    src_dc_victim    = 4'h6,
    src_ic_parity    = 4'h7,
    src_tag_issue    = 4'h8,
    src_tag_retry    = 4'h9
  } err_src_t;
  // one detected error from the checkers
  typedef struct packed {
    logic        valid;
    err_src_t    src;
    logic        from_board;   // fill from board cache, else memory
    logic        double_bit;
    logic        used_by_load;
    logic        speculative;
    logic        target_qw;    // error is in the target quadword
    logic        port_one;     // tag parity on port 1
    logic        second_store; // store error close behind another
    logic [42:6] block_addr;
    logic [7:0]  syn0;
    logic [7:0]  syn1;
    logic [63:0] vaddr;
  } err_event_t;
  // recovery commands to the pipeline and cache controller
  typedef struct packed {
    logic icache_flush;
    logic replay_trap;
    logic map_stall;
    logic write_bad_dest;
    logic retain_lq;
    logic evict_to_victim;
    logic write_back_dc;
    logic retry_load;
    logic keep_check_bits;
    logic correct_data;
    logic data_fault;
    logic forward_uncorrected;
  } recovery_t;
endpackage : fill_ecc_error_pkg

/* verification/fill_ecc_error_handler_sva.sv */
// port-level assertions for the fill ecc error handler
`timescale 1ns/1ps
`default_nettype none
module fill_ecc_error_handler_sva
  import fill_ecc_error_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // event and mode inputs
  input wire err_event_t  err_in,
  input wire logic        read_err_type,
  input wire logic        privileged_firmware_mode,
  // register port
  input wire logic [3:0]  reg_addr,
  input wire logic [63:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [63:0] reg_rdata,
  // exceptions and recovery
  input wire logic        machine_check,
  input wire logic        corrected_read_interrupt,
  input wire recovery_t   recovery
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire ev = err_in.valid; // event strobe
  // enables are invisible here, so only enable-free effects are checked
  property p_rdata_idle; !reg_rd |=> reg_rdata == 64'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  property p_machine_check_fw; privileged_firmware_mode |-> !machine_check; endproperty
  a_machine_check_fw: assert property (p_machine_check_fw) else $error("check shown in firmware mode");
  property p_icache; ev && err_in.src == src_ic_parity |=> recovery.icache_flush; endproperty
  a_icache: assert property (p_icache) else $error("no icache flush");
  property p_tag_issue; ev && err_in.src == src_tag_issue |=> recovery.data_fault; endproperty
  a_tag_issue: assert property (p_tag_issue) else $error("no data fault");
  // a fresh used fill starts the replay flow when no scrub is running
  property p_used_fill;
    ev && err_in.src == src_data_fill && err_in.used_by_load && err_in.target_qw
      && !err_in.speculative && !err_in.double_bit && !recovery.map_stall
      |=> recovery.write_bad_dest && recovery.replay_trap && recovery.retain_lq;
  endproperty
  a_used_fill: assert property (p_used_fill) else $error("no replay flow");
  property p_stall_drop;
    $fell(recovery.map_stall) |-> $past(recovery.retry_load) || $past(recovery.retry_load, 2);
  endproperty
  a_stall_drop: assert property (p_stall_drop) else $error("stall dropped early");
  property p_evict_start; $rose(recovery.evict_to_victim) |-> $past(read_err_type); endproperty
  a_evict_start: assert property (p_evict_start) else $error("evict without read type");
  property p_victim;
    ev && err_in.src == src_dc_victim && !corrected_read_interrupt
      |=> !corrected_read_interrupt && recovery.correct_data;
  endproperty
  a_victim: assert property (p_victim) else $error("victim error not silent");
  property p_second;
    ev && err_in.src == src_dc_store && err_in.second_store |=> !recovery.correct_data;
  endproperty
  a_second: assert property (p_second) else $error("second store corrected");
  property p_probe;
    ev && err_in.src == src_probe && !err_in.double_bit
      |=> recovery.forward_uncorrected && !recovery.correct_data;
  endproperty
  a_probe: assert property (p_probe) else $error("probe block corrected");
  // main scenarios reached
  c_retry: cover property (recovery.retry_load);
  c_machine_check: cover property (machine_check);
  c_crd: cover property ($rose(corrected_read_interrupt));
endmodule : fill_ecc_error_handler_sva

bind fill_ecc_error_handler fill_ecc_error_handler_sva i_sva (
  .clk(clk), .arst_n(arst_n), .err_in(err_in), .read_err_type(read_err_type),
  .privileged_firmware_mode(privileged_firmware_mode), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .machine_check(machine_check), .corrected_read_interrupt(corrected_read_interrupt),
  .recovery(recovery)
);
`default_nettype wire

/* verification/fill_ecc_error_handler_test.sv */
// self-checking bench for the fill ecc error handler
`timescale 1ns/1ps
`default_nettype none
`include "fill_ecc_error_handler_cfg.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module fill_ecc_error_handler_test
  import fill_ecc_error_pkg::*;
;
  // stimulus and observed ports
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  err_event_t  err_in = '0;
  logic        read_err_type = 1'b0;
  logic        privileged_firmware_mode = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [63:0] reg_wdata = 64'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [63:0] reg_rdata;
  logic        machine_check;
  logic        corrected_read_interrupt;
  recovery_t   recovery;
  int          errors = 0;
  int          n_checks = 0;
  localparam logic [36:0] addr_a = 37'h15a5a5a5a5; // two distinct block addresses
  localparam logic [36:0] addr_b = 37'h0c3c3c3c3c;
  localparam logic [63:0] syn_w = 64'hc53c; // {syn1, syn0}
  always #5 clk = ~clk;
  fill_ecc_error_handler i_fill_ecc_error_handler (
    .clk(clk), .arst_n(arst_n), .err_in(err_in), .read_err_type(read_err_type),
    .privileged_firmware_mode(privileged_firmware_mode), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .machine_check(machine_check), .corrected_read_interrupt(corrected_read_interrupt),
    .recovery(recovery));
  // flags are {from_board, double_bit, used_by_load, speculative, target_qw}
  function automatic err_event_t mk(err_src_t s, logic [4:0] f, logic [36:0] a);
    err_event_t e;
    e = '0;
    e.valid = 1'b1;
    e.src = s;
    {e.from_board, e.double_bit, e.used_by_load, e.speculative, e.target_qw} = f;
    e.block_addr = a;
    {e.syn1, e.syn0} = 16'hc53c;
    e.vaddr = 64'h7fff_0012_3440;
    return e;
  endfunction : mk
  // one-cycle event; returns in the cycle where its effects show
  task automatic fire(input err_event_t e);
    @(posedge clk);
    err_in <= e;
    @(posedge clk);
    err_in <= '0;
    #1;
  endtask : fire
  task automatic wr(input logic [3:0] a, input logic [63:0] d);
    @(posedge clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // read data are looked at in the single cycle they stand
  task automatic reg_is(input logic [3:0] a, input logic [63:0] e);
    @(posedge clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask : reg_is
  // clears every status and pending flag
  task automatic clr;
    wr(`ADDR_CACHE_STATUS, 64'h0);
    wr(`ADDR_DATA_CACHE_STAT, 64'h1f);
    wr(`ADDR_INSTR_STATUS, 64'h1);
    wr(`ADDR_MM_STATUS, 64'h1);
    wr(`ADDR_EXCEPTION, 64'h3);
  endtask : clr
  task automatic t_ifill;
    reg_is(`ADDR_CONTROL, 64'h3);
    reg_is(4'hf, 64'h0);
    fire(mk(src_instr_fill, 5'b00001, addr_a));
    `CHK({machine_check, corrected_read_interrupt, recovery.icache_flush}, 3'b111)
    reg_is(`ADDR_EXCEPTION, 64'h3);
    repeat (4) @(posedge clk);
    reg_is(`ADDR_CACHE_STATUS, 64'h1);
    reg_is(`ADDR_ERROR_ADDRESS, {21'h0, addr_a, 6'h0});
    reg_is(`ADDR_SYNDROME, syn_w);
    clr();
  endtask : t_ifill
  task automatic t_fill_unused;
    fire(mk(src_data_fill, 5'b00001, addr_b));
    `CHK({recovery.write_bad_dest, recovery.map_stall, corrected_read_interrupt}, 3'b001)
    reg_is(`ADDR_CACHE_STATUS, 64'h2);
    clr();
    fire(mk(src_data_fill, 5'b00100, addr_b));
    `CHK({recovery.keep_check_bits, recovery.map_stall}, 2'b10)
    fire(mk(src_data_fill, 5'b10001, addr_b));
    reg_is(`ADDR_CACHE_STATUS, 64'ha);
    clr();
  endtask : t_fill_unused
  // used fill: replay, wait for read type, evict, write back, retry
  task automatic t_fill_used;
    int stage;
    logic stall_ok;
    stage = 0;
    stall_ok = 1'b1;
    fire(mk(src_data_fill, 5'b00101, addr_b));
    `CHK({recovery.write_bad_dest, recovery.retain_lq}, 2'b11)
    `CHK({recovery.replay_trap, recovery.map_stall, corrected_read_interrupt}, 3'b110)
    reg_is(`ADDR_CACHE_STATUS, 64'h2);
    reg_is(`ADDR_ERROR_ADDRESS, {21'h0, addr_b, 6'h0});
    `CHK(recovery.evict_to_victim, 1'b0)
    @(posedge clk);
    read_err_type <= 1'b1;
    @(posedge clk);
    read_err_type <= 1'b0;
    repeat (12) begin
      #1;
      if (stage < 3 && !recovery.map_stall) stall_ok = 1'b0;
      if (stage == 0 && recovery.evict_to_victim) stage = 1;
      if (stage == 1 && recovery.write_back_dc) stage = 2;
      if (stage == 2 && recovery.retry_load) stage = 3;
      @(posedge clk);
    end
    `CHK(stage, 3)
    `CHK(stall_ok, 1'b1)
    `CHK(corrected_read_interrupt, 1'b1)
    reg_is(`ADDR_DATA_CACHE_STAT, 64'h4);
    clr();
    fire(mk(src_data_fill, 5'b00111, addr_a));
    `CHK(corrected_read_interrupt, 1'b1)
    reg_is(`ADDR_CACHE_STATUS, 64'h0);
    reg_is(`ADDR_ERROR_ADDRESS, {21'h0, addr_b, 6'h0});
    clr();
  endtask : t_fill_used
  task automatic t_probe_dc;
    err_event_t e;
    fire(mk(src_probe, 5'b10001, addr_a));
    `CHK({recovery.forward_uncorrected, corrected_read_interrupt}, 2'b11)
    reg_is(`ADDR_CACHE_STATUS, 64'h3);
    reg_is(`ADDR_SYNDROME, syn_w);
    clr();
    fire(mk(src_dc_load, 5'b00001, addr_b));
    `CHK({recovery.correct_data, corrected_read_interrupt}, 2'b11)
    reg_is(`ADDR_ERROR_ADDRESS, {21'h0, addr_a[36:14], addr_b[13:0], 6'h0});
    reg_is(`ADDR_CACHE_STATUS, 64'h8);
    clr();
    fire(mk(src_dc_victim, 5'b00001, addr_b));
    `CHK({recovery.correct_data, corrected_read_interrupt}, 2'b10)
    reg_is(`ADDR_DATA_CACHE_STAT, 64'h0);
    e = mk(src_dc_store, 5'b00001, addr_b);
    fire(e);
    `CHK({recovery.correct_data, corrected_read_interrupt}, 2'b11)
    reg_is(`ADDR_DATA_CACHE_STAT, 64'h8);
    clr();
    e.second_store = 1'b1;
    fire(e);
    `CHK({recovery.correct_data, machine_check}, 2'b01)
    reg_is(`ADDR_DATA_CACHE_STAT, 64'h18);
    clr();
  endtask : t_probe_dc
  task automatic t_parity;
    err_event_t e;
    fire(mk(src_ic_parity, 5'b00000, addr_a));
    `CHK({recovery.icache_flush, corrected_read_interrupt}, 2'b11)
    reg_is(`ADDR_INSTR_STATUS, 64'h1);
    fire(mk(src_tag_issue, 5'b00000, addr_a));
    `CHK(recovery.data_fault, 1'b1)
    reg_is(`ADDR_MM_STATUS, 64'h1);
    reg_is(`ADDR_FAULT_VA, 64'h7fff_0012_3440);
    clr();
    for (int p = 0; p < 2; p++) begin
      e = mk(src_tag_retry, 5'b00000, addr_a);
      e.port_one = p[0];
      fire(e);
      `CHK(machine_check, 1'b1)
      reg_is(`ADDR_DATA_CACHE_STAT, p[0] ? 64'h2 : 64'h1);
      clr();
    end
  endtask : t_parity
  // four double-bit codes; first one raised inside firmware mode
  task automatic t_double;
    for (int i = 0; i < 4; i++) begin
      privileged_firmware_mode <= (i == 0);
      fire(mk(i[0] ? src_data_fill : src_instr_fill, {~i[1], 4'b1001}, addr_a));
      if (i[1]) `CHK(recovery.keep_check_bits, 1'b1)
      `CHK(machine_check, i != 0)
      @(posedge clk);
      privileged_firmware_mode <= 1'b0;
      #1 `CHK(machine_check, 1'b1)
      reg_is(`ADDR_CACHE_STATUS, 64'(i + 4));
      clr();
    end
    wr(`ADDR_CONTROL, 64'h2);
    fire(mk(src_data_fill, 5'b01001, addr_a));
    `CHK(machine_check, 1'b0)
    wr(`ADDR_CONTROL, 64'h3);
    clr();
  endtask : t_double
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  // reset, then every scenario in turn
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    t_ifill();
    t_fill_unused();
    t_fill_used();
    t_probe_dc();
    t_parity();
    t_double();
    test_done();
  end
endmodule : fill_ecc_error_handler_test
`default_nettype wire
